// file: core/cbc_bus_ctrl.sv
// bus cycle sequencer: address and data pins, strobes, waits, takeover, interrupt enable
`timescale 1ns/10ps
`default_nettype none
module cbc_bus_ctrl #(
    parameter int ADDR_W = cbc_pkg::ADDR_W_DEF,
    parameter int DATA_W = cbc_pkg::DATA_W_DEF
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // core request side
    input  wire logic                  cyc_req,
    input  wire cbc_pkg::cbc_kind_t    cyc_kind,
    input  wire logic [ADDR_W-1:0]     cyc_addr,
    input  wire logic [DATA_W-1:0]     cyc_wdata,
    input  wire logic [DATA_W-1:0]     cyc_status,
    output logic                       cyc_ack,
    output logic                       cyc_done,
    output logic [DATA_W-1:0]          cyc_rdata,
    // program counter
    input  wire logic                  pc_load,
    input  wire logic [ADDR_W-1:0]     pc_value,
    output logic [ADDR_W-1:0]          pc,
    // instruction events
    input  wire logic                  instr_end,
    input  wire logic                  irq_on_instruction,
    input  wire logic                  irq_off_instruction,
    output logic                       irq_accept,
    // address and data pins
    output logic [ADDR_W-1:0]          addr_out,
    output logic                       addr_oe,
    output logic [DATA_W-1:0]          data_out,
    output logic                       data_oe,
    input  wire logic [DATA_W-1:0]     data_in,
    // control pins
    output logic                       sync_out,
    output logic                       data_input_strobe,
    input  wire logic                  ready_in,
    output logic                       stall_ind,
    output logic                       store_n,
    input  wire logic                  hold_req,
    output logic                       bus_release_ack,
    input  wire logic                  irq_req,
    output logic                       irq_enable_flag
);
    import cbc_pkg::*;

    // widths the address and port logic can serve
    if (ADDR_W != 2 * DATA_W || DATA_W < 1) begin : g_bad_width
        $error("address width must be twice the data width");
    end

    cbc_phase_if ph ();

    cbc_phase_gen u_phase (
        .clk   (clk),
        .rst_n (rst_n),
        .ph    (ph)
    );

    // pin synchronisers
    logic [2:0]        ctl_s1_ff;
    logic [2:0]        ctl_s2_ff;
    logic [DATA_W-1:0] dat_s1_ff;
    logic [DATA_W-1:0] dat_s2_ff;
    logic              ready_s;
    logic              hold_s;
    logic              irq_s;

    // sequencer state
    cbc_state_t        state_ff;
    cbc_state_t        nxt_state;
    cbc_kind_t         kind_ff;
    cbc_kind_t         nxt_kind;
    logic              tick;
    logic              take;
    logic              hold_rec;
    logic              hold_pend_ff;
    logic              halt_ret_ff;
    logic              nxt_ack;
    logic              nxt_float;
    logic              float_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic [ADDR_W-1:0] pc_ff;
    logic              take_irq;
    logic              irq_pend_ff;
    logic              fetch_start;

    // machine cycle kinds that read the data bus
    function automatic logic is_read(input cbc_kind_t k);
        return k == K_FETCH || k == K_MRD || k == K_IN;
    endfunction : is_read

    // machine cycle kinds that drive data out
    function automatic logic is_write(input cbc_kind_t k);
        return k == K_MWR || k == K_OUT;
    endfunction : is_write

    // bus address of a cycle; a port number shows on both halves
    function automatic logic [ADDR_W-1:0] cyc_address(input cbc_kind_t k,
                                                      input logic [ADDR_W-1:0] a,
                                                      input logic [ADDR_W-1:0] p);
        if (k == K_FETCH) begin
            return p;
        end else if (k == K_IN || k == K_OUT) begin
            return {a[DATA_W-1:0], a[DATA_W-1:0]};
        end
        return a;
    endfunction : cyc_address

    // two flip-flops on every pin input before any logic reads it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_s1_ff <= '0;
            ctl_s2_ff <= '0;
            dat_s1_ff <= '0;
            dat_s2_ff <= '0;
        end else begin
            ctl_s1_ff <= {irq_req, hold_req, ready_in};
            ctl_s2_ff <= ctl_s1_ff;
            dat_s1_ff <= data_in;
            dat_s2_ff <= dat_s1_ff;
        end
    end

    assign ready_s = ctl_s2_ff[0];
    assign hold_s  = ctl_s2_ff[1];
    assign irq_s   = ctl_s2_ff[2];

    // state changes only at the end of phase two
    assign tick     = ph.ph2;
    assign take     = tick && state_ff == S_IDLE && cyc_req;
    assign hold_rec = tick && (state_ff == S_TWO || state_ff == S_STALL)
                      && ready_s && hold_s;

    // interrupt sampled at instruction end, or at a state boundary while halted
    assign take_irq = irq_s && irq_enable_flag && !irq_pend_ff
                      && state_ff != S_HOLD
                      && (instr_end || (state_ff == S_HALT && tick));

    // next bus state
    always_comb begin
        nxt_state = state_ff;
        nxt_kind  = take ? cyc_kind : kind_ff;
        if (tick) begin
            unique case (state_ff)
                S_IDLE: begin
                    if (cyc_req) begin
                        nxt_state = S_ONE;
                    end
                end
                S_ONE: begin
                    nxt_state = S_TWO;
                end
                S_TWO, S_STALL: begin
                    nxt_state = ready_s ? S_THREE : S_STALL;
                end
                S_THREE: begin
                    if (hold_pend_ff) begin
                        nxt_state = S_HOLD;
                    end else if (kind_ff == K_HALT) begin
                        nxt_state = S_HALT;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
                S_HOLD: begin
                    if (!hold_s) begin
                        nxt_state = halt_ret_ff ? S_HALT : S_IDLE;
                    end
                end
                S_HALT: begin
                    if (hold_s) begin
                        nxt_state = S_HOLD;
                    end else if (take_irq) begin
                        nxt_state = S_IDLE;
                    end
                end
                default: begin
                    nxt_state = S_IDLE;
                end
            endcase
        end
    end

    // acknowledge from state three on reads, from the hold state after writes
    always_comb begin
        nxt_ack = nxt_state == S_HOLD;
        if (nxt_state == S_THREE) begin
            nxt_ack = state_ff == S_THREE ? bus_release_ack
                                          : hold_rec && is_read(kind_ff);
        end
        nxt_float = nxt_ack && (float_ff || !tick);
    end

    // sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= S_IDLE;
            kind_ff  <= K_FETCH;
            wdata_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            kind_ff  <= nxt_kind;
            if (take) begin
                wdata_ff <= cyc_wdata;
            end
        end
    end

    // takeover bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_pend_ff    <= 1'b0;
            halt_ret_ff     <= 1'b0;
            bus_release_ack <= 1'b0;
            float_ff        <= 1'b0;
        end else begin
            if (hold_rec) begin
                hold_pend_ff <= 1'b1;
            end else if (nxt_state == S_HOLD) begin
                hold_pend_ff <= 1'b0;
            end
            if (tick && state_ff != S_HOLD && nxt_state == S_HOLD) begin
                halt_ret_ff <= state_ff == S_HALT;
            end
            bus_release_ack <= nxt_ack;
            float_ff        <= nxt_float;
        end
    end

    // pin drivers, all registered; enables and strobes from the next state, address from the request or the program counter, data from the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_out          <= '0;
            addr_oe           <= 1'b1;
            data_out          <= '0;
            data_oe           <= 1'b0;
            sync_out          <= 1'b0;
            data_input_strobe <= 1'b0;
            stall_ind         <= 1'b0;
            store_n           <= 1'b1;
        end else begin
            if (take) begin
                addr_out <= cyc_address(cyc_kind, cyc_addr, pc_ff);
                data_out <= cyc_status;
            end else if (tick && state_ff == S_ONE) begin
                data_out <= wdata_ff;
            end
            addr_oe  <= !nxt_float;
            data_oe  <= !nxt_float && (nxt_state == S_ONE
                        || (is_write(nxt_kind) && (nxt_state == S_TWO
                        || nxt_state == S_STALL || nxt_state == S_THREE)));
            sync_out <= nxt_state == S_ONE;
            data_input_strobe <= is_read(nxt_kind) && (nxt_state == S_TWO
                                 || nxt_state == S_STALL || nxt_state == S_THREE);
            stall_ind <= nxt_state == S_STALL;
            store_n   <= !(is_write(nxt_kind) && nxt_state == S_THREE);
        end
    end

    // core answers: taken, done with read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_ack   <= 1'b0;
            cyc_done  <= 1'b0;
            cyc_rdata <= '0;
        end else begin
            cyc_ack  <= take;
            cyc_done <= tick && state_ff == S_THREE;
            if (tick && state_ff == S_THREE && is_read(kind_ff)) begin
                cyc_rdata <= dat_s2_ff;
            end
        end
    end

    // program counter: cleared by reset, steps on each fetch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= ADDR_W'(PC_RESET);
        end else if (pc_load) begin
            pc_ff <= pc_value;
        end else if (tick && state_ff == S_THREE && kind_ff == K_FETCH) begin
            pc_ff <= pc_ff + ADDR_W'(PC_STEP);
        end
    end

    assign pc = pc_ff;

    assign fetch_start = take && cyc_kind == K_FETCH;

    // interrupt enable flag; an accepted interrupt clears it when the next fetch starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable_flag <= 1'b0;
            irq_pend_ff     <= 1'b0;
            irq_accept      <= 1'b0;
        end else begin
            irq_accept <= take_irq;
            if (take_irq) begin
                irq_pend_ff <= 1'b1;
            end else if (fetch_start) begin
                irq_pend_ff <= 1'b0;
            end
            if (irq_on_instruction) begin
                irq_enable_flag <= 1'b1;
            end else if (irq_off_instruction || (fetch_start && irq_pend_ff)) begin
                irq_enable_flag <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a machine cycle opens with one state of strobe and status
    sequence s_start;
        $rose(sync_out);
    endsequence

    sequence s_one_state;
        (sync_out && data_oe) [*2] ##1 !sync_out;
    endsequence

    chk_sync_width: assert property (s_start |-> s_one_state)
        else $error("start strobe not one bus state");
    chk_status_drive: assert property (sync_out |-> data_oe && addr_oe)
        else $error("status word not driven");
    chk_input_mode: assert property (data_input_strobe |-> !data_oe)
        else $error("data driven during input strobe");

    // a low memory-done at the state-two boundary gives a full stall state
    sequence s_missed_ready;
        tick && state_ff == S_TWO && !ready_s;
    endsequence

    chk_stall_entry: assert property (s_missed_ready |=> stall_ind [*2])
        else $error("no stall state inserted");
    chk_stall_exit: assert property (stall_ind && tick && ready_s
        |=> !stall_ind && state_ff == S_THREE)
        else $error("stall not left on memory-done");
    chk_store_stable: assert property (!store_n && $past(!store_n)
        |-> $stable(data_out) && data_oe)
        else $error("data moved under store strobe");

    // acknowledge first, buses floated one phase later
    sequence s_ack_rise;
        $rose(bus_release_ack);
    endsequence

    chk_release_float: assert property (s_ack_rise |-> addr_oe ##1 !addr_oe && !data_oe)
        else $error("float not one phase after acknowledge");
    chk_release_hold: assert property (bus_release_ack && $past(bus_release_ack)
        |-> !addr_oe && !data_oe)
        else $error("bus driven during takeover");
    chk_ack_write: assert property (state_ff == S_THREE && is_write(kind_ff)
        |-> !bus_release_ack)
        else $error("acknowledge inside write state three");
    chk_irq_refuse: assert property (irq_accept |-> $past(irq_enable_flag)
        && $past(state_ff) != S_HOLD)
        else $error("interrupt taken while refused");
    chk_ie_clear: assert property ($fell(irq_enable_flag)
        |-> $past(irq_off_instruction) || sync_out)
        else $error("enable flag dropped without cause");
endmodule : cbc_bus_ctrl
`default_nettype wire

// file: core/cbc_pkg.sv
// shared constants and types of the bus cycle sequencer
package cbc_pkg;

    // bus widths
    localparam int ADDR_W_DEF = 16;
    localparam int DATA_W_DEF = 8;

    // program counter start point and fetch step
    localparam int PC_RESET   = 0;
    localparam int PC_STEP    = 1;

    // the phase counter restarts at phase one
    localparam logic PH_START = 1'b0;

    // kind of machine cycle asked for by the core
    typedef enum logic [2:0] {
        K_FETCH = 3'h0,
        K_MRD   = 3'h1,
        K_MWR   = 3'h2,
        K_IN    = 3'h3,
        K_OUT   = 3'h4,
        K_HALT  = 3'h5
    } cbc_kind_t;

    // bus states of the sequencer
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_ONE   = 3'h1,
        S_TWO   = 3'h2,
        S_STALL = 3'h3,
        S_THREE = 3'h4,
        S_HOLD  = 3'h5,
        S_HALT  = 3'h6
    } cbc_state_t;

endpackage : cbc_pkg

// file: core/cbc_phase_if.sv
// two-phase timing strobe shared between the phase generator and the sequencer
`timescale 1ns/10ps
`default_nettype none
interface cbc_phase_if;
    logic ph2;   // high in the second clock of each bus state

    modport gen (output ph2);
    modport rcv (input ph2);
endinterface : cbc_phase_if
`default_nettype wire

// file: core/cbc_phase_gen.sv
// phase generator: splits every bus state into phase one and phase two
`timescale 1ns/10ps
`default_nettype none
module cbc_phase_gen (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    // phase strobe
    cbc_phase_if.gen    ph
);
    import cbc_pkg::*;

    logic ph2_ff;

    // alternate phase one and phase two on every clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph2_ff <= PH_START;
        end else begin
            ph2_ff <= ~ph2_ff;
        end
    end

    assign ph.ph2 = ph2_ff;

    // phases strictly alternate
    chk_phase_toggle: assert property (@(posedge clk) disable iff (!rst_n)
        ph2_ff |=> !ph2_ff) else $error("phase two repeated");
endmodule : cbc_phase_gen
`default_nettype wire

// file: dv/cbc_mem_model.sv
// memory and i/o partner model on the far side of the bus pins
`timescale 1ns/10ps
`default_nettype none
module cbc_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // bus pins from the sequencer
    input  wire logic [15:0] addr_out,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    input  wire logic        sync_out,
    input  wire logic        data_input_strobe,
    input  wire logic        store_n,
    // answers to the sequencer
    output logic [7:0]       data_in,
    output logic             ready_in,
    // observations for the bench
    output logic [7:0]       status_ff,
    output logic [7:0]       wr_data_ff,
    output logic [15:0]      wr_addr_ff,
    output logic             wr_bad_ff
);
    logic [15:0] addr_ff;
    logic [7:0]  last_ff;
    logic        sync_q_ff;
    logic        store_q_ff;
    logic [2:0]  cnt_ff;
    logic [1:0]  slow;
    // low address bits pick a slow region: 0, 2 or 3 stall states wanted
    assign slow = (addr_out[1:0] == 2'h3) ? 2'h0 : addr_out[1:0];
    // memory-done held low while slow, so the device stalls
    assign ready_in = !(cnt_ff != 3'h0 || (sync_out && slow != 2'h0));
    // the driven value while data_oe is high, read data only while the strobe is up, else a value differing from the last
    assign data_in = data_oe ? data_out : data_input_strobe ? (addr_ff[7:0] ^ 8'h5A) : ~last_ff;
    // latch address and status at cycle start, watch the store strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {addr_ff, last_ff, sync_q_ff, store_q_ff, cnt_ff} <= '0;
            {status_ff, wr_data_ff, wr_addr_ff, wr_bad_ff} <= '0;
        end else begin
            last_ff <= data_in;
            sync_q_ff <= sync_out;
            store_q_ff <= !store_n;
            if (sync_out && !sync_q_ff) begin
                addr_ff <= addr_out;
                cnt_ff <= (slow == 2'h0) ? 3'h0 : {slow, 1'b0} + 3'h2;
            end else if (cnt_ff != 3'h0) begin
                cnt_ff <= cnt_ff - 3'h1;
            end
            if (sync_out && data_oe) begin
                status_ff <= data_out;
            end
            if (!store_n) begin
                wr_data_ff <= data_out;
                wr_addr_ff <= addr_out;
                if (store_q_ff && data_out != wr_data_ff) begin
                    wr_bad_ff <= 1'b1;
                end
            end
        end
    end
endmodule : cbc_mem_model
`default_nettype wire

// file: dv/cpu_bus_cycle_control_tb.sv
// self-checking bench of the bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module cpu_bus_cycle_control_tb;
    import cbc_pkg::*;
    typedef struct {cbc_kind_t k; logic [15:0] a; logic [7:0] w; logic [7:0] s; logic [15:0] pc;} cbc_note_t;
    logic clk, rst_n, cyc_req, cyc_ack, cyc_done, pc_load, instr_end, irq_accept;
    logic irq_on_instruction, irq_off_instruction, addr_oe, data_oe, sync_out, data_input_strobe;
    logic ready_in, stall_ind, store_n, hold_req, bus_release_ack, irq_req, irq_enable_flag, wr_bad;
    cbc_kind_t   cyc_kind;
    logic [15:0] cyc_addr, pc_value, pc, addr_out, pc_exp, m_waddr;
    logic [7:0]  cyc_wdata, cyc_status, cyc_rdata, data_out, data_in, m_status, m_wdata;
    logic [31:0] seed = 32'h54;
    cbc_note_t   q[$];
    cbc_note_t   nt;
    logic        stall_seen = 1'b0;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    cbc_bus_ctrl dut (.clk, .rst_n, .cyc_req, .cyc_kind, .cyc_addr, .cyc_wdata, .cyc_status, .cyc_ack,
        .cyc_done, .cyc_rdata, .pc_load, .pc_value, .pc, .instr_end, .irq_on_instruction,
        .irq_off_instruction, .irq_accept, .addr_out, .addr_oe, .data_out, .data_oe, .data_in, .sync_out,
        .data_input_strobe, .ready_in, .stall_ind, .store_n, .hold_req, .bus_release_ack, .irq_req,
        .irq_enable_flag);
    cbc_mem_model mem (.clk, .rst_n, .addr_out, .data_out, .data_oe, .sync_out, .data_input_strobe,
        .store_n, .data_in, .ready_in, .status_ff(m_status), .wr_data_ff(m_wdata), .wr_addr_ff(m_waddr),
        .wr_bad_ff(wr_bad));
    // xorshift source of random values
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // one machine cycle request, held until taken; expectation noted in the queue
    task automatic bus_cycle(input cbc_kind_t k, input logic [15:0] a);
        int n;
        cbc_note_t e;
        e.k = k;
        // a fetch goes out on the program counter, not on the given address
        e.a = (k == K_FETCH) ? pc_exp : (k == K_IN || k == K_OUT) ? {a[7:0], a[7:0]} : a;
        e.w = 8'(rnd());
        e.s = 8'(rnd());
        if (k == K_FETCH) pc_exp++;
        e.pc = pc_exp;
        cyc_kind = k;
        cyc_addr = a;
        cyc_wdata = e.w;
        cyc_status = e.s;
        cyc_req = 1'b1;
        q.push_back(e);
        n = 0;
        do begin @(negedge clk); n++; end while (cyc_ack !== 1'b1 && n < 40);
        `CHK("ack", 1'b1, cyc_ack)
        `CHK("sync", 1'b1, sync_out)
        `CHK("status drive", 1'b1, data_oe)
    endtask : bus_cycle
    // instruction end pulse, then look for an accepted interrupt
    task automatic instr_pulse(input logic exp);
        logic seen;
        seen = 1'b0;
        instr_end = 1'b1;
        repeat (6) begin @(negedge clk); instr_end = 1'b0; seen |= (irq_accept === 1'b1); end
        `CHK("accept", exp, seen)
    endtask : instr_pulse
    // wait until every noted cycle has ended
    task automatic drain();
        int n;
        n = 0;
        while (q.size() != 0 && n < 100) begin @(negedge clk); n++; end
        `CHK("drained", 0, q.size())
    endtask : drain
    // clock generator
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin n_errors++; $display("Error timeout expected end seen hang"); final_report(); end
    end
    // result watcher: each ended cycle is compared with the oldest note
    always @(negedge clk) begin
        if (rst_n && cyc_done === 1'b1) begin
            `CHK("note", 1'b1, q.size() != 0)
            if (q.size() != 0) begin
                nt = q.pop_front();
                `CHK("status", nt.s, m_status)
                if (nt.k == K_MWR || nt.k == K_OUT) begin
                    `CHK("wdata", nt.w, m_wdata)
                    `CHK("waddr", nt.a, m_waddr)
                end else if (nt.k != K_HALT) begin
                    `CHK("rdata", nt.a[7:0] ^ 8'h5A, cyc_rdata)
                end
                `CHK("stall", nt.a[1:0] == 2'h1 || nt.a[1:0] == 2'h2, stall_seen)
                if (nt.k == K_FETCH) `CHK("pc", nt.pc, pc)
            end
            stall_seen = 1'b0;
        end else if (stall_ind === 1'b1) stall_seen = 1'b1;
    end
    // main sequence
    initial begin
        int n;
        {rst_n, cyc_req, pc_load, instr_end, irq_on_instruction, irq_off_instruction, hold_req, irq_req} = '0;
        {cyc_addr, pc_value, cyc_wdata, cyc_status} = '0;
        cyc_kind = K_FETCH;
        repeat (12) @(negedge clk);
        `CHK("pc reset", 16'h0000, pc)
        `CHK("enable reset", 1'b0, irq_enable_flag)
        `CHK("release reset", 1'b0, bus_release_ack)
        rst_n = 1'b1;
        @(negedge clk);
        pc_value = 16'(rnd());
        pc_exp = pc_value;
        pc_load = 1'b1;
        @(negedge clk);
        pc_load = 1'b0;
        for (int i = 0; i < 20; i++) bus_cycle(cbc_kind_t'(i % 5), 16'(rnd()));
        cyc_req = 1'b0;
        drain();
        `CHK("store stable", 1'b0, wr_bad)
        irq_off_instruction = 1'b1;
        irq_req = 1'b1;
        @(negedge clk);
        irq_off_instruction = 1'b0;
        repeat (4) @(negedge clk);
        instr_pulse(1'b0);
        irq_on_instruction = 1'b1;
        @(negedge clk);
        irq_on_instruction = 1'b0;
        @(negedge clk);
        `CHK("enable on", 1'b1, irq_enable_flag)
        instr_pulse(1'b1);
        irq_req = 1'b0;
        bus_cycle(K_FETCH, 16'h0040);
        cyc_req = 1'b0;
        drain();
        `CHK("enable auto off", 1'b0, irq_enable_flag)
        irq_on_instruction = 1'b1;
        hold_req = 1'b1;
        @(negedge clk);
        irq_on_instruction = 1'b0;
        bus_cycle(K_MRD, 16'h1230);
        cyc_req = 1'b0;
        n = 0;
        while (bus_release_ack !== 1'b1 && n < 40) begin @(negedge clk); n++; end
        `CHK("release", 1'b1, bus_release_ack)
        `CHK("release in state three", 1, q.size())
        @(negedge clk);
        `CHK("addr float", 1'b0, addr_oe)
        `CHK("data float", 1'b0, data_oe)
        irq_req = 1'b1;
        repeat (4) @(negedge clk);
        instr_pulse(1'b0);
        irq_req = 1'b0;
        hold_req = 1'b0;
        n = 0;
        while (bus_release_ack !== 1'b0 && n < 40) begin @(negedge clk); n++; end
        @(negedge clk);
        `CHK("addr back", 1'b1, addr_oe)
        // halt cycle, then an interrupt while halted wakes the sequencer
        bus_cycle(K_HALT, 16'h0004);
        cyc_req = 1'b0;
        drain();
        irq_req = 1'b1;
        instr_pulse(1'b1);
        irq_req = 1'b0;
        drain();
        final_report();
    end
endmodule : cpu_bus_cycle_control_tb
`default_nettype wire
